// *** core/pmcfg_regs.sv ***
// Manufacturer configuration register bank behind the PMBus command layer.
// Assumes an upstream SMBus engine delivering one decoded command per
// cmd_valid_in pulse; block transfers arrive as one byte per pulse.
`timescale 1ns/1ps

// Function
// [RULE_01] Device-type register reports a fixed 6-bit module name per variant.
// [RULE_02] Vout gain resets to 0x2000, accepts 0x1999..0x2666, kept in flash.
// [RULE_03] Vout offset uses linear exponent -12; host must write that exponent.
// [RULE_04] Vin gain resets to 0x2000, accepts 0x1999..0x2666, kept in flash.
// [RULE_05] Vin offset uses exponent -3; host writes it, value persists.
// [RULE_06] Iout gain accepts 0x1999..0x2666 and scales current readback.
// [RULE_07] Iout offset uses exponent -4; host encodes offsets with it.
// [RULE_08] Six calibration registers ignore writes while write-protect is set.
// [RULE_09] Write-protect bit 1 locks protected writes, 0 permits them.
// [RULE_10] Firmware revision is read-only, a byte of two nibbles.
// [RULE_11] Bit 4 enables alert response address; bits 7:5 read zero.
// [RULE_12] Bits 3:0 map the two multi-purpose pins among three codes.
// [RULE_13] Load-sharing variants accept only pin map code 0000.
// [RULE_14] On/off bit 1 ignores or ANDs the secondary on/off input.
// [RULE_15] On/off bit 0 sets secondary polarity; bits 7:2 read zero.
// [RULE_16] Power-good polarity bit 0 sets pin sense; upper bits read zero.
// [RULE_17] Date/location/serial is a 12-byte block, write-protected too.
// [RULE_18] Bad gain or exponent writes are dropped and flag invalid data.
module pmcfg_regs #(
  parameter logic [5:0] MODULE_NAME = 6'h2a, // Arbitrary value
  parameter logic [7:0] FW_REVISION = 8'h10, // Arbitrary value
  parameter bit         LOAD_SHARE  = 1'b0
) (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_write_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [15:0] cmd_wdata_in,
  input  wire logic [3:0]  cmd_byte_idx_in,
  output logic             rsp_valid_out,
  output logic      [15:0] rsp_rdata_out,
  output logic             invalid_data_out,
  output logic             invalid_cmd_out,
  input  wire logic        alert_line_in,
  output logic             ara_respond_out,
  input  wire logic        primary_on_in,
  input  wire logic        power_good_in,
  input  wire logic        trim_or_control_pin_in,
  input  wire logic        second_control_pin_in,
  output logic             second_control_pin_out,
  output logic             second_control_pin_oe_out,
  output logic             trim_active_out,
  output logic             output_enable_out,
  output logic      [15:0] vout_gain_out,
  output logic      [15:0] vout_offset_out,
  output logic      [15:0] vin_gain_out,
  output logic      [15:0] vin_offset_out,
  output logic      [15:0] iout_gain_out,
  output logic      [15:0] iout_offset_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic gain_ok(input logic [15:0] v);
    return (v >= pmcfg_pkg::GAIN_MIN) && (v <= pmcfg_pkg::GAIN_MAX);
  endfunction

  function automatic logic exp_ok(input logic [15:0] v,
                                  input logic [4:0]  e);
    return v[15:pmcfg_pkg::EXP_LSB] == e;
  endfunction

  function automatic logic map_ok(input logic [3:0] m);
    if (LOAD_SHARE) begin
      return m == pmcfg_pkg::MAP_SEC_PG;
    end
    return (m == pmcfg_pkg::MAP_SEC_PG) || (m == pmcfg_pkg::MAP_TRIM_PG) ||
           (m == pmcfg_pkg::MAP_TRIM_SEC);
  endfunction

  logic        write_protect_enable;
  logic [15:0] vout_gain;
  logic [15:0] vout_offset;
  logic [15:0] vin_gain;
  logic [15:0] vin_offset;
  logic [15:0] iout_gain;
  logic [15:0] iout_offset;
  logic [4:0]  pin_alert;
  logic [1:0]  onoff_logic;
  logic        pg_pol;
  logic        wr;
  logic        rd;
  logic        locked;
  logic        known;
  logic        bad_data;
  logic [7:0]  serial_byte;
  logic        trim_pin;
  logic        c2_pin;
  logic        sec_raw;
  logic        sec_active;
  logic        pg_mapped;
  logic [7:0]  rd_code;
  pmcfg_pkg::pmcfg_rd_state_t rd_state;

  assign wr     = cmd_valid_in && cmd_write_in;
  assign rd     = cmd_valid_in && !cmd_write_in;
  assign locked = write_protect_enable; // see [RULE_09]

  always_comb begin
    known = 1'b1;
    case (cmd_code_in)
      pmcfg_pkg::CMD_DEVICE_TYPE, pmcfg_pkg::CMD_VOUT_GAIN,
      pmcfg_pkg::CMD_VOUT_OFFSET, pmcfg_pkg::CMD_VIN_GAIN,
      pmcfg_pkg::CMD_VIN_OFFSET, pmcfg_pkg::CMD_IOUT_GAIN,
      pmcfg_pkg::CMD_IOUT_OFFSET, pmcfg_pkg::CMD_PIN_MAP_ALERT,
      pmcfg_pkg::CMD_ONOFF_LOGIC, pmcfg_pkg::CMD_PG_POLARITY,
      pmcfg_pkg::CMD_DATE_LOC_SERIAL: known = 1'b1;
      pmcfg_pkg::CMD_FW_REV: known = !cmd_write_in; // see [RULE_10]
      default: known = 1'b0;
    endcase
  end

  // Range and exponent screening applies even when locked out
  always_comb begin
    case (cmd_code_in)
      pmcfg_pkg::CMD_VOUT_GAIN,
      pmcfg_pkg::CMD_VIN_GAIN,
      pmcfg_pkg::CMD_IOUT_GAIN: bad_data = !gain_ok(cmd_wdata_in);
      pmcfg_pkg::CMD_VOUT_OFFSET:
        bad_data = !exp_ok(cmd_wdata_in, pmcfg_pkg::EXP_VOUT);
      pmcfg_pkg::CMD_VIN_OFFSET:
        bad_data = !exp_ok(cmd_wdata_in, pmcfg_pkg::EXP_VIN);
      pmcfg_pkg::CMD_IOUT_OFFSET:
        bad_data = !exp_ok(cmd_wdata_in, pmcfg_pkg::EXP_IOUT);
      pmcfg_pkg::CMD_PIN_MAP_ALERT: bad_data = !map_ok(cmd_wdata_in[3:0]);
      default: bad_data = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Write protect
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      write_protect_enable <= 1'b0;
    end else if (wr && cmd_code_in == pmcfg_pkg::CMD_DEVICE_TYPE) begin
      write_protect_enable <= cmd_wdata_in[pmcfg_pkg::WPE_BIT]; // see [RULE_09]
    end
  end

  // ---------------------------------------------------------------
  // Calibration registers
  // ---------------------------------------------------------------
  // Reset stands in for the flash image; restore from flash is upstream
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vout_gain   <= pmcfg_pkg::GAIN_RESET;
      vin_gain    <= pmcfg_pkg::GAIN_RESET;
      iout_gain   <= pmcfg_pkg::GAIN_RESET;
      vout_offset <= {pmcfg_pkg::EXP_VOUT, 11'h000};
      vin_offset  <= {pmcfg_pkg::EXP_VIN, 11'h000};
      iout_offset <= {pmcfg_pkg::EXP_IOUT, 11'h000};
    end else if (wr && !locked && !bad_data) begin // see [RULE_08]
      case (cmd_code_in)
        pmcfg_pkg::CMD_VOUT_GAIN:   vout_gain   <= cmd_wdata_in; // see [RULE_02]
        pmcfg_pkg::CMD_VIN_GAIN:    vin_gain    <= cmd_wdata_in; // see [RULE_04]
        pmcfg_pkg::CMD_IOUT_GAIN:   iout_gain   <= cmd_wdata_in; // see [RULE_06]
        pmcfg_pkg::CMD_VOUT_OFFSET: vout_offset <= cmd_wdata_in; // see [RULE_03]
        pmcfg_pkg::CMD_VIN_OFFSET:  vin_offset  <= cmd_wdata_in; // see [RULE_05]
        pmcfg_pkg::CMD_IOUT_OFFSET: iout_offset <= cmd_wdata_in; // see [RULE_07]
        default: ;
      endcase
    end
  end

  assign vout_gain_out   = vout_gain;
  assign vout_offset_out = vout_offset;
  assign vin_gain_out    = vin_gain;
  assign vin_offset_out  = vin_offset;
  assign iout_gain_out   = iout_gain;
  assign iout_offset_out = iout_offset;

  // ---------------------------------------------------------------
  // Pin and logic configuration
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_alert <= 5'h00;
    end else if (wr && cmd_code_in == pmcfg_pkg::CMD_PIN_MAP_ALERT &&
                 !bad_data) begin
      pin_alert <= cmd_wdata_in[4:0]; // see [RULE_12] see [RULE_13]
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      onoff_logic <= 2'h0;
    end else if (wr && cmd_code_in == pmcfg_pkg::CMD_ONOFF_LOGIC) begin
      onoff_logic <= cmd_wdata_in[1:0]; // see [RULE_15]
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pg_pol <= 1'b0;
    end else if (wr && cmd_code_in == pmcfg_pkg::CMD_PG_POLARITY) begin
      pg_pol <= cmd_wdata_in[pmcfg_pkg::PG_POL_BIT]; // see [RULE_16]
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      invalid_data_out <= 1'b0;
      invalid_cmd_out  <= 1'b0;
    end else begin
      invalid_data_out <= wr && known && bad_data; // see [RULE_18]
      invalid_cmd_out  <= cmd_valid_in && !known;
    end
  end

  // ---------------------------------------------------------------
  // Serial block store
  // ---------------------------------------------------------------
  pmcfg_serial_mem u_serial (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (wr && !locked &&
                  cmd_code_in == pmcfg_pkg::CMD_DATE_LOC_SERIAL), // see [RULE_17]
    .addr_in     (cmd_byte_idx_in),
    .wdata_in    (cmd_wdata_in[7:0]),
    .rdata_out   (serial_byte)
  );

  // ---------------------------------------------------------------
  // Read path: two cycles so the memory byte is registered too
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_state <= pmcfg_pkg::PMCFG_IDLE;
      rd_code  <= 8'h00;
    end else begin
      case (rd_state)
        pmcfg_pkg::PMCFG_IDLE: begin
          if (rd && known) begin
            rd_state <= pmcfg_pkg::PMCFG_FETCH;
            rd_code  <= cmd_code_in;
          end
        end
        pmcfg_pkg::PMCFG_FETCH: rd_state <= pmcfg_pkg::PMCFG_REPLY;
        pmcfg_pkg::PMCFG_REPLY: rd_state <= pmcfg_pkg::PMCFG_IDLE;
        default: rd_state <= pmcfg_pkg::PMCFG_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsp_rdata_out <= 16'h0000;
      rsp_valid_out <= 1'b0;
    end else begin
      rsp_valid_out <= rd_state == pmcfg_pkg::PMCFG_FETCH;
      if (rd_state == pmcfg_pkg::PMCFG_FETCH) begin
        case (rd_code)
          pmcfg_pkg::CMD_DEVICE_TYPE: rsp_rdata_out <=
            {8'h00, MODULE_NAME, write_protect_enable, 1'b0}; // see [RULE_01]
          pmcfg_pkg::CMD_VOUT_GAIN:     rsp_rdata_out <= vout_gain;
          pmcfg_pkg::CMD_VOUT_OFFSET:   rsp_rdata_out <= vout_offset;
          pmcfg_pkg::CMD_VIN_GAIN:      rsp_rdata_out <= vin_gain;
          pmcfg_pkg::CMD_VIN_OFFSET:    rsp_rdata_out <= vin_offset;
          pmcfg_pkg::CMD_IOUT_GAIN:     rsp_rdata_out <= iout_gain;
          pmcfg_pkg::CMD_IOUT_OFFSET:   rsp_rdata_out <= iout_offset;
          pmcfg_pkg::CMD_FW_REV:
            rsp_rdata_out <= {8'h00, FW_REVISION}; // see [RULE_10]
          pmcfg_pkg::CMD_PIN_MAP_ALERT:
            rsp_rdata_out <= {11'h000, pin_alert}; // see [RULE_11]
          pmcfg_pkg::CMD_ONOFF_LOGIC:
            rsp_rdata_out <= {14'h0000, onoff_logic}; // see [RULE_15]
          pmcfg_pkg::CMD_PG_POLARITY:
            rsp_rdata_out <= {15'h0000, pg_pol}; // see [RULE_16]
          pmcfg_pkg::CMD_DATE_LOC_SERIAL:
            rsp_rdata_out <= {8'h00, serial_byte};
          default: rsp_rdata_out <= 16'h0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Pins and enables
  // ---------------------------------------------------------------
  pmcfg_sync u_sync_trim (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .pin_in      (trim_or_control_pin_in),
    .level_out   (trim_pin)
  );

  pmcfg_sync u_sync_c2 (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .pin_in      (second_control_pin_in),
    .level_out   (c2_pin)
  );

  // With no pin mapped as secondary on/off the secondary counts as active
  always_comb begin
    case (pin_alert[3:0])
      pmcfg_pkg::MAP_SEC_PG:   sec_raw = trim_pin;
      pmcfg_pkg::MAP_TRIM_SEC: sec_raw = c2_pin;
      default:                 sec_raw = onoff_logic[pmcfg_pkg::SEC_POL_BIT];
    endcase
  end

  assign sec_active = onoff_logic[pmcfg_pkg::SEC_POL_BIT] ? sec_raw
                                                          : !sec_raw;
  assign pg_mapped  = pin_alert[3:0] != pmcfg_pkg::MAP_TRIM_SEC;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      output_enable_out         <= 1'b0;
      second_control_pin_out    <= 1'b0;
      second_control_pin_oe_out <= 1'b0;
      trim_active_out           <= 1'b0;
      ara_respond_out           <= 1'b0;
    end else begin
      output_enable_out <= primary_on_in &&
        (!onoff_logic[pmcfg_pkg::COMBINE_BIT] || sec_active); // see [RULE_14]
      second_control_pin_out    <= pg_pol ? power_good_in
                                          : !power_good_in; // see [RULE_16]
      second_control_pin_oe_out <= pg_mapped; // see [RULE_12]
      trim_active_out <= pin_alert[3:0] != pmcfg_pkg::MAP_SEC_PG;
      ara_respond_out <= alert_line_in &&
        pin_alert[pmcfg_pkg::ALERT_RESP_BIT]; // see [RULE_11]
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_gain_locked: assert property ( // see [RULE_08]
    wr && locked && cmd_code_in == pmcfg_pkg::CMD_VOUT_GAIN
    |=> $stable(vout_gain)) else $error("Locked gain write took effect");
  a_gain_range: assert property ( // see [RULE_02]
    gain_ok(vout_gain) && gain_ok(vin_gain) && gain_ok(iout_gain))
    else $error("Gain out of range");
  a_exp_vout: assert property ( // see [RULE_03]
    vout_offset[15:11] == pmcfg_pkg::EXP_VOUT)
    else $error("Vout offset exponent wrong");
  a_exp_vin_iout: assert property ( // see [RULE_05]
    vin_offset[15:11] == pmcfg_pkg::EXP_VIN &&
    iout_offset[15:11] == pmcfg_pkg::EXP_IOUT)
    else $error("Vin or iout offset exponent wrong");
  a_bad_flagged: assert property ( // see [RULE_18]
    wr && known && bad_data |=> invalid_data_out)
    else $error("Invalid data not flagged");
  a_read_latency: assert property ( // see [RULE_10]
    rd && known && rd_state == pmcfg_pkg::PMCFG_IDLE
    |-> ##2 rsp_valid_out) else $error("Read answer not on time");
  a_name_read: assert property ( // see [RULE_01]
    rsp_valid_out && rd_code == pmcfg_pkg::CMD_DEVICE_TYPE
    |-> rsp_rdata_out[7:2] == MODULE_NAME) else $error("Wrong module name");
  a_map_legal: assert property ( // see [RULE_13]
    map_ok(pin_alert[3:0])) else $error("Illegal pin map stored");
  a_combine_off: assert property ( // see [RULE_14]
    !onoff_logic[1] && $stable(onoff_logic) |=> output_enable_out ==
    $past(primary_on_in)) else $error("Secondary not ignored");
  a_ara_gate: assert property ( // see [RULE_11]
    !pin_alert[4] && $stable(pin_alert) |=> !ara_respond_out)
    else $error("Alert response while disabled");

  c_locked_write: cover property (wr && locked);
  c_bad_gain: cover property (wr && bad_data ##1 invalid_data_out);
  c_serial_read: cover property (
    rd && cmd_code_in == pmcfg_pkg::CMD_DATE_LOC_SERIAL ##2 rsp_valid_out);
endmodule

// *** core/pmcfg_pkg.sv ***
// Constants shared by the manufacturer configuration register bank.
// Assumes a command decoder upstream that hands over whole SMBus words.
package pmcfg_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_DEVICE_TYPE      = 8'hd0;
  localparam logic [7:0] CMD_VOUT_GAIN        = 8'hd1;
  localparam logic [7:0] CMD_VOUT_OFFSET      = 8'hd2;
  localparam logic [7:0] CMD_VIN_GAIN         = 8'hd3;
  localparam logic [7:0] CMD_VIN_OFFSET       = 8'hd4;
  localparam logic [7:0] CMD_IOUT_GAIN        = 8'hd6;
  localparam logic [7:0] CMD_IOUT_OFFSET      = 8'hd7;
  localparam logic [7:0] CMD_FW_REV           = 8'hdb;
  localparam logic [7:0] CMD_PIN_MAP_ALERT    = 8'he0;
  localparam logic [7:0] CMD_ONOFF_LOGIC      = 8'he1;
  localparam logic [7:0] CMD_PG_POLARITY      = 8'he2;
  localparam logic [7:0] CMD_DATE_LOC_SERIAL  = 8'hf0;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         WPE_BIT              = 1;
  localparam int         NAME_LSB             = 2;
  localparam int         ALERT_RESP_BIT       = 4;
  localparam int         COMBINE_BIT          = 1;
  localparam int         SEC_POL_BIT          = 0;
  localparam int         PG_POL_BIT           = 0;
  localparam int         EXP_LSB              = 11;
  localparam logic [15:0] GAIN_RESET          = 16'h2000;
  localparam logic [15:0] GAIN_MIN            = 16'h1999;
  localparam logic [15:0] GAIN_MAX            = 16'h2666;
  localparam logic [4:0] EXP_VOUT             = 5'h14;
  localparam logic [4:0] EXP_VIN              = 5'h1d;
  localparam logic [4:0] EXP_IOUT             = 5'h1c;
  localparam logic [7:0] BYTE_RESET           = 8'h00;
  localparam int         SERIAL_BYTES         = 12;

  // ---------------------------------------------------------------
  // Pin mapping codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MAP_SEC_PG           = 4'h0;
  localparam logic [3:0] MAP_TRIM_PG          = 4'h1;
  localparam logic [3:0] MAP_TRIM_SEC         = 4'h2;

  typedef enum logic [1:0] {
    PMCFG_IDLE  = 2'b00,
    PMCFG_FETCH = 2'b01,
    PMCFG_REPLY = 2'b10
  } pmcfg_rd_state_t;

endpackage

// *** core/pmcfg_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to core_clk_in.
`timescale 1ns/1ps
module pmcfg_sync (
  input  wire logic core_clk_in,
  input  wire logic arst_n_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1;
  logic s2;
  logic s3;

  // ---------------------------------------------------------------
  // Stages; only s2 reads s1
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_out <= 1'b0;
    end else if (s2 == s3) begin
      level_out <= s3;
    end
  end
endmodule

// *** core/pmcfg_serial_mem.sv ***
// Twelve-byte store for the date, location and serial block.
// Assumes the caller gates writes; read data leave from a register.
`timescale 1ns/1ps
module pmcfg_serial_mem (
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       wr_en_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [pmcfg_pkg::SERIAL_BYTES];

  // ---------------------------------------------------------------
  // Storage; out-of-range indices are dropped
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < pmcfg_pkg::SERIAL_BYTES; i++) begin
        mem[i] <= pmcfg_pkg::BYTE_RESET;
      end
    end else if (wr_en_in && (32'(addr_in) < pmcfg_pkg::SERIAL_BYTES)) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= pmcfg_pkg::BYTE_RESET;
    end else if (32'(addr_in) < pmcfg_pkg::SERIAL_BYTES) begin
      rdata_out <= mem[addr_in];
    end else begin
      rdata_out <= pmcfg_pkg::BYTE_RESET;
    end
  end
endmodule

// *** tb/pmcfg_host.sv ***
// Host model standing in for the SMBus command engine.
// Assumes one clock; requests change at the falling edge.
`timescale 1ns/1ps
module pmcfg_host (
  input  wire logic        core_clk_in,
  input  wire logic        rsp_valid_in,
  input  wire logic [15:0] rsp_rdata_in,
  input  wire logic        bad_in,
  output logic             cmd_valid_out,
  output logic             cmd_write_out,
  output logic      [7:0]  cmd_code_out,
  output logic      [15:0] cmd_wdata_out,
  output logic      [3:0]  cmd_byte_idx_out,
  output logic             hung_out
);
  // ---------------------------------------------------------------
  // Requests
  // ---------------------------------------------------------------
  initial begin
    {cmd_valid_out, cmd_write_out, cmd_code_out} = 10'h000;
    {cmd_wdata_out, cmd_byte_idx_out, hung_out} = 21'h000000;
  end
  // Data word is inverted once released so a stale value never matches
  task automatic send(input logic w, input logic [7:0] c,
                      input logic [15:0] d, input logic [3:0] i);
    @(negedge core_clk_in);
    {cmd_write_out, cmd_code_out, cmd_wdata_out} = {w, c, d};
    cmd_byte_idx_out = i;
    cmd_valid_out = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_out = 1'b0;
    cmd_wdata_out = ~cmd_wdata_out;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
                    input logic [3:0] i, output logic bad);
    send(1'b1, c, d, i);
    bad = bad_in;
    @(negedge core_clk_in);
    bad = bad | bad_in;
  endtask
  // Waiting for the answer also gives the three-cycle read spacing
  task automatic rd(input logic [7:0] c, input logic [3:0] i,
                    output logic [15:0] q);
    int k;
    send(1'b0, c, 16'h0000, i);
    k = 0;
    while (rsp_valid_in !== 1'b1 && k < 4) begin
      @(negedge core_clk_in);
      k++;
    end
    if (k == 4) hung_out = 1'b1;
    q = rsp_rdata_in;
  endtask
endmodule

// *** tb/pmcfg_regs_tb.sv ***
// Self-checking bench for the configuration register bank.
// Assumes the host model drives commands; pins are driven here.
`timescale 1ns/1ps
module pmcfg_regs_tb;
  localparam logic [5:0] NAME = 6'h2a; // Arbitrary value
  localparam logic [7:0] FW   = 8'h10; // Arbitrary value
  logic        core_clk_in, arst_n_in, cv, cw, idat, icmd, rv, hung, bad;
  logic        alert, pri, pg, tpin, sdrv, ara, spo, spoe, trim, oen;
  logic [3:0]  bi;
  logic [7:0]  cc;
  logic [15:0] wd, rq, q, v, lfsr;
  logic [15:0] o [6];
  logic [15:0] ev [6];
  logic [7:0]  cal [6];
  logic [3:0]  pt [5];
  wire         spin = spoe ? spo : sdrv;
  int          failures, checked;

  pmcfg_regs #(.MODULE_NAME(NAME), .FW_REVISION(FW)) u_dut (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cv),
    .cmd_write_in(cw), .cmd_code_in(cc), .cmd_wdata_in(wd),
    .cmd_byte_idx_in(bi), .rsp_valid_out(rv), .rsp_rdata_out(rq),
    .invalid_data_out(idat), .invalid_cmd_out(icmd),
    .alert_line_in(alert), .ara_respond_out(ara), .primary_on_in(pri),
    .power_good_in(pg), .trim_or_control_pin_in(tpin),
    .second_control_pin_in(spin), .second_control_pin_out(spo),
    .second_control_pin_oe_out(spoe), .trim_active_out(trim),
    .output_enable_out(oen), .vout_gain_out(o[0]), .vout_offset_out(o[1]),
    .vin_gain_out(o[2]), .vin_offset_out(o[3]), .iout_gain_out(o[4]),
    .iout_offset_out(o[5]));
  pmcfg_host u_host (.core_clk_in(core_clk_in), .rsp_valid_in(rv),
    .rsp_rdata_in(rq), .bad_in(idat | icmd), .cmd_valid_out(cv),
    .cmd_write_out(cw), .cmd_code_out(cc), .cmd_wdata_out(wd),
    .cmd_byte_idx_out(bi), .hung_out(hung));

  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] step(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction
  function automatic logic [4:0] ex(input int j);
    return j == 1 ? 5'h14 : j == 3 ? 5'h1d : 5'h1c;
  endfunction
  function automatic logic [15:0] pick(input int j, t, input logic [15:0] s);
    if (j % 2 == 1) return {t == 0 ? ex(j) + 5'h01 : ex(j), s[10:0]};
    case (t)
      0: return 16'h1998;
      1: return 16'h1999;
      2: return 16'h2666;
      3: return 16'h2667;
      default: return 16'h1999 + s % 16'h0cce;
    endcase
  endfunction
  function automatic bit ok(input int j, input logic [15:0] x);
    if (j % 2 == 1) return x[15:11] == ex(j);
    return x >= 16'h1999 && x <= 16'h2666;
  endfunction
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input logic [7:0] c, input logic [15:0] d, input bit eb);
    u_host.wr(c, d, 4'h0, bad);
    chk("invalid flag", {15'h0000, bad}, {15'h0000, eb});
  endtask
  task automatic r(input logic [7:0] c, input logic [3:0] i, logic [15:0] e);
    u_host.rd(c, i, q);
    chk("read data", q, e);
  endtask
  // Fixed wait covers the pin synchroniser plus the output register
  task automatic settle;
    repeat (8) @(negedge core_clk_in);
  endtask
  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge hung) begin
    failures++;
    print_verdict();
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n_in, alert, pri, pg, tpin, sdrv} = 6'h00;
    {failures, checked} = {32'sd0, 32'sd0};
    lfsr = 16'h8074;
    cal = '{8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hd7};
    ev = '{16'h2000, 16'ha000, 16'h2000, 16'he800, 16'h2000, 16'he000};
    pt = '{4'b1111, 4'b1100, 4'b1001, 4'b1010, 4'b0001};
    repeat (16) @(negedge core_clk_in);
    arst_n_in = 1'b1;
    for (int j = 0; j < 6; j++) r(cal[j], 4'h0, ev[j]);
    for (int j = 0; j < 6; j++) begin
      for (int t = 0; t < 5; t++) begin
        lfsr = step(lfsr);
        v = pick(j, t, lfsr);
        w(cal[j], v, !ok(j, v));
        if (ok(j, v)) ev[j] = v;
        r(cal[j], 4'h0, ev[j]);
      end
      chk("calibration out", o[j], ev[j]);
    end
    for (int i = 0; i < 12; i++) u_host.wr(8'hf0, 16'h00a0 + i, i, bad);
    for (int i = 0; i < 13; i++) r(8'hf0, i, i < 12 ? 16'h00a0 + i : 0);
    w(8'hd0, 16'h0002, 1'b0);
    r(8'hd0, 4'h0, {8'h00, NAME, 2'b10});
    for (int j = 0; j < 6; j++) begin
      w(cal[j], j % 2 ? {ex(j), 11'h155} : 16'h2222, 1'b0);
      r(cal[j], 4'h0, ev[j]);
    end
    u_host.wr(8'hf0, 16'h0055, 4'h0, bad);
    r(8'hf0, 4'h0, 16'h00a0);
    w(8'hd0, 16'h0000, 1'b0);
    r(8'hd0, 4'h0, {8'h00, NAME, 2'b00});
    w(8'hdb, 16'h0055, 1'b1);
    r(8'hdb, 4'h0, {8'h00, FW});
    alert = 1'b1;
    w(8'he0, 16'h0013, 1'b1);
    w(8'he0, 16'h0011, 1'b0);
    r(8'he0, 4'h0, 16'h0011);
    settle();
    chk("alert answer", {15'h0000, ara}, 16'h0001);
    chk("trim", {14'h0000, trim, spoe}, 16'h0003);
    w(8'he0, 16'h0002, 1'b0);
    settle();
    chk("trim", {14'h0000, trim, spoe}, 16'h0002);
    w(8'he0, 16'h0000, 1'b0);
    settle();
    chk("map zero", {14'h0000, ara, trim, spoe}, 16'h0001);
    pri = 1'b1;
    for (int k = 0; k < 5; k++) begin
      w(8'he1, {14'h0000, pt[k][3:2]}, 1'b0);
      tpin = pt[k][1];
      settle();
      chk("output enable", {15'h0000, oen}, {15'h0000, pt[k][0]});
    end
    w(8'he1, 16'h00ff, 1'b0);
    r(8'he1, 4'h0, 16'h0003);
    pg = 1'b1;
    w(8'he2, 16'h00ff, 1'b0);
    r(8'he2, 4'h0, 16'h0001);
    settle();
    chk("power good pin", {15'h0000, spo}, 16'h0001);
    w(8'he2, 16'h0000, 1'b0);
    settle();
    chk("power good pin", {15'h0000, spo}, 16'h0000);
    w(8'he0, 16'h0002, 1'b0);
    settle();
    chk("output enable", {15'h0000, oen}, 16'h0000);
    sdrv = 1'b1;
    settle();
    chk("output enable", {15'h0000, oen}, 16'h0001);
    print_verdict();
  end
endmodule
